// *** verilog/mixer_gain_config_regs.sv ***
// Mixer gain configuration register bank with an AHB-Lite slave port.
// Assumes a single master, whole-word transfers, and hclk at 50 MHz.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
// What this block does
// - Left output register bits 11:9 hold the left aux gain code, reset 000.
// - Left output register bits 7:5 hold the right amplifier gain code, reset 000.
// - Left output register bits 3:1 hold the left amplifier gain code, reset 000.
// - Right output register bits 15:13 hold the right aux gain code, reset 000.
// - Right output register bits 7:5 hold the right amplifier gain code, reset 000.
// - Right output register bits 3:1 hold the left amplifier gain code, reset 000.
// - Left record register bits 11:9 hold the left aux gain code, reset 000.
// - Left record register bits 3:1 hold the second left input gain code, reset 000.
// - Left record register bit 0 gives the left amplifier a 20 dB boost when set.
// - A zero gain code disconnects the path entirely.
// - Codes 001 and 010 give -12 dB and -9 dB.
// - Code 111 gives the maximum of +6 dB.
module mixer_gain_config_regs
(
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output logic      [31:0]                hrdata,
   output logic                            hreadyout,
   output logic                            hresp,
   output mix_gain_pkg::path_ctrl_t        aux_l_to_out_l_gain,
   output mix_gain_pkg::path_ctrl_t        amp_r_to_out_l_gain,
   output mix_gain_pkg::path_ctrl_t        amp_l_to_out_l_gain,
   output mix_gain_pkg::path_ctrl_t        aux_r_to_out_r_gain,
   output mix_gain_pkg::path_ctrl_t        amp_r_to_out_r_gain,
   output mix_gain_pkg::path_ctrl_t        amp_l_to_out_r_gain,
   output mix_gain_pkg::path_ctrl_t        aux_l_to_rec_l_gain,
   output mix_gain_pkg::path_ctrl_t        second_l_to_rec_l_gain,
   output logic                            amp_l_rec_boost,
   output logic      [15:0]                left_out_word,
   output logic      [15:0]                right_out_word,
   output logic      [15:0]                left_rec_word
);

   // Stored registers; only writable bits are ever set.
   logic [15:0] left_output_mix_gain;
   logic [15:0] right_output_mix_gain;
   logic [15:0] left_record_mix_gain;

   // Latched address phase.
   logic        wr_pend;
   logic        rd_pend;
   logic [7:0]  idx_pend;

   // Address phase decode.
   wire         take     = hsel && hready && (htrans == mix_gain_pkg::HTRANS_NONSEQ ||
                                              htrans == mix_gain_pkg::HTRANS_SEQ);
   wire  [7:0]  idx_now  = haddr[mix_gain_pkg::ADDR_SHIFT +: 8];

   // Per-register write strobes in the data phase.
   wire         wr_lo    = wr_pend && (idx_pend == mix_gain_pkg::IDX_LEFT_OUT);
   wire         wr_ro    = wr_pend && (idx_pend == mix_gain_pkg::IDX_RIGHT_OUT);
   wire         wr_lr    = wr_pend && (idx_pend == mix_gain_pkg::IDX_LEFT_REC);

   // Read selection by index.
   function automatic logic [15:0] read_sel(input logic [7:0] idx,
                                            input logic [15:0] lo,
                                            input logic [15:0] ro,
                                            input logic [15:0] lr);
      case (idx)
         mix_gain_pkg::IDX_LEFT_OUT:  read_sel = lo;
         mix_gain_pkg::IDX_RIGHT_OUT: read_sel = ro;
         mix_gain_pkg::IDX_LEFT_REC:  read_sel = lr;
         default:                     read_sel = 16'h0000;
      endcase
   endfunction : read_sel

   // Zero-wait slave, always OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = mix_gain_pkg::HRESP_OKAY;

   // Address phase capture.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend  <= 1'b0;
         rd_pend  <= 1'b0;
         idx_pend <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend  <= take && hwrite;
         rd_pend  <= take && !hwrite;
         idx_pend <= idx_now;
      end
   end

   // Read data registered at the address phase so it stands in the data phase.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (take && !hwrite)
         hrdata <= {16'h0000, read_sel(idx_now, left_output_mix_gain,
                                       right_output_mix_gain, left_record_mix_gain)};
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         left_output_mix_gain  <= 16'h0000;
         right_output_mix_gain <= 16'h0000;
         left_record_mix_gain  <= 16'h0000;
      end
      else
      begin
         if (wr_lo)
            left_output_mix_gain  <= hwdata[15:0] & mix_gain_pkg::MASK_LEFT_OUT;
         if (wr_ro)
            right_output_mix_gain <= hwdata[15:0] & mix_gain_pkg::MASK_RIGHT_OUT;
         if (wr_lr)
            left_record_mix_gain  <= hwdata[15:0] & mix_gain_pkg::MASK_LEFT_REC;
      end
   end

   // Raw register words for the analogue side.
   assign left_out_word  = left_output_mix_gain;
   assign right_out_word = right_output_mix_gain;
   assign left_rec_word  = left_record_mix_gain;

   // Field extraction feeding the decoders.
   logic [2:0] codes [8];
   assign codes[0] = left_output_mix_gain[mix_gain_pkg::POS_AUX_L_OUT_L +: 3];
   assign codes[1] = left_output_mix_gain[mix_gain_pkg::POS_AMP_R_OUT_L +: 3];
   assign codes[2] = left_output_mix_gain[mix_gain_pkg::POS_AMP_L_OUT_L +: 3];
   assign codes[3] = right_output_mix_gain[mix_gain_pkg::POS_AUX_R_OUT_R +: 3];
   assign codes[4] = right_output_mix_gain[mix_gain_pkg::POS_AMP_R_OUT_R +: 3];
   assign codes[5] = right_output_mix_gain[mix_gain_pkg::POS_AMP_L_OUT_R +: 3];
   assign codes[6] = left_record_mix_gain[mix_gain_pkg::POS_AUX_L_REC_L +: 3];
   assign codes[7] = left_record_mix_gain[mix_gain_pkg::POS_SEC_L_REC_L +: 3];

   mix_gain_pkg::path_ctrl_t paths [8];

   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_dec
         gain_decode u_dec
         (
            .code (codes[g]),
            .path (paths[g])
         );
      end
   endgenerate

   assign aux_l_to_out_l_gain    = paths[0];
   assign amp_r_to_out_l_gain    = paths[1];
   assign amp_l_to_out_l_gain    = paths[2];
   assign aux_r_to_out_r_gain    = paths[3];
   assign amp_r_to_out_r_gain    = paths[4];
   assign amp_l_to_out_r_gain    = paths[5];
   assign aux_l_to_rec_l_gain    = paths[6];
   assign second_l_to_rec_l_gain = paths[7];

   assign amp_l_rec_boost = left_record_mix_gain[mix_gain_pkg::POS_BOOST];

   // Write then reflect in the field next cycle.
   property p_lo_write;
      @(posedge hclk) disable iff (!hresetn)
      wr_lo |=> left_output_mix_gain[11:9] == $past(hwdata[11:9]);
   endproperty
   a_lo_write: assert property (p_lo_write) else $error("left aux field not written");

   property p_ro_write;
      @(posedge hclk) disable iff (!hresetn)
      wr_ro |=> right_output_mix_gain[15:13] == $past(hwdata[15:13]);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("right aux field not written");

   property p_lr_boost;
      @(posedge hclk) disable iff (!hresetn)
      wr_lr |=> amp_l_rec_boost == $past(hwdata[0]);
   endproperty
   a_lr_boost: assert property (p_lr_boost) else $error("boost bit not written");

   property p_reserved_zero;
      @(posedge hclk) disable iff (!hresetn)
      (left_output_mix_gain & ~mix_gain_pkg::MASK_LEFT_OUT) == 16'h0000 &&
      (right_output_mix_gain & ~mix_gain_pkg::MASK_RIGHT_OUT) == 16'h0000 &&
      (left_record_mix_gain & ~mix_gain_pkg::MASK_LEFT_REC) == 16'h0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_disconnect;
      @(posedge hclk) disable iff (!hresetn)
      (codes[2] == 3'h0) |-> !amp_l_to_out_l_gain.connect;
   endproperty
   a_disconnect: assert property (p_disconnect) else $error("zero code connected");

   property p_min_gain;
      @(posedge hclk) disable iff (!hresetn)
      (codes[1] == 3'h1) |-> amp_r_to_out_l_gain.gain_db == -8'sd12;
   endproperty
   a_min_gain: assert property (p_min_gain) else $error("code 1 not -12 dB");

   property p_max_gain;
      @(posedge hclk) disable iff (!hresetn)
      (codes[6] == 3'h7) |-> aux_l_to_rec_l_gain.gain_db == 8'sd6;
   endproperty
   a_max_gain: assert property (p_max_gain) else $error("code 7 not +6 dB");

   property p_mid_gain;
      @(posedge hclk) disable iff (!hresetn)
      (codes[7] == 3'h5) |-> second_l_to_rec_l_gain.gain_db == 8'sd0;
   endproperty
   a_mid_gain: assert property (p_mid_gain) else $error("code 5 not 0 dB");

   property p_read_back;
      @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && idx_now == mix_gain_pkg::IDX_RIGHT_OUT && !wr_pend)
      |=> hrdata[15:0] == right_output_mix_gain;
   endproperty
   a_read_back: assert property (p_read_back) else $error("read data mismatch");

   property p_lo_amp_r;
      @(posedge hclk) disable iff (!hresetn)
      wr_lo |=> codes[1] == $past(hwdata[mix_gain_pkg::POS_AMP_R_OUT_L +: 3]);
   endproperty
   a_lo_amp_r: assert property (p_lo_amp_r) else $error("field not written");

   property p_lo_amp_l;
      @(posedge hclk) disable iff (!hresetn)
      wr_lo |=> codes[2] == $past(hwdata[mix_gain_pkg::POS_AMP_L_OUT_L +: 3]);
   endproperty
   a_lo_amp_l: assert property (p_lo_amp_l) else $error("field not written");

   property p_ro_amp_r;
      @(posedge hclk) disable iff (!hresetn)
      wr_ro |=> codes[4] == $past(hwdata[mix_gain_pkg::POS_AMP_R_OUT_R +: 3]);
   endproperty
   a_ro_amp_r: assert property (p_ro_amp_r) else $error("field not written");

   property p_ro_amp_l;
      @(posedge hclk) disable iff (!hresetn)
      wr_ro |=> codes[5] == $past(hwdata[mix_gain_pkg::POS_AMP_L_OUT_R +: 3]);
   endproperty
   a_ro_amp_l: assert property (p_ro_amp_l) else $error("field not written");

   property p_lr_aux;
      @(posedge hclk) disable iff (!hresetn)
      wr_lr |=> codes[6] == $past(hwdata[mix_gain_pkg::POS_AUX_L_REC_L +: 3]);
   endproperty
   a_lr_aux: assert property (p_lr_aux) else $error("field not written");

   property p_lr_second;
      @(posedge hclk) disable iff (!hresetn)
      wr_lr |=> codes[7] == $past(hwdata[mix_gain_pkg::POS_SEC_L_REC_L +: 3]);
   endproperty
   a_lr_second: assert property (p_lr_second) else $error("field not written");

   // Every decoded path, so one bad decoder cannot hide.
   for (genvar q = 0; q < 8; q++)
   begin : g_path_chk
      property p_path_connect;
         @(posedge hclk) disable iff (!hresetn)
         paths[q].connect == (codes[q] != 3'h0);
      endproperty
      a_path_connect: assert property (p_path_connect) else $error("bad connect");
      property p_path_low;
         @(posedge hclk) disable iff (!hresetn)
         (codes[q] == 3'h2) |-> paths[q].gain_db == -8'sd9;
      endproperty
      a_path_low: assert property (p_path_low) else $error("code 2 not -9 dB");
      property p_path_step;
         @(posedge hclk) disable iff (!hresetn)
         ((codes[q] == 3'h3) |-> paths[q].gain_db == -8'sd6) and
         ((codes[q] == 3'h6) |-> paths[q].gain_db == 8'sd3);
      endproperty
      a_path_step: assert property (p_path_step) else $error("mid code wrong");
   end

   property p_read_high;
      @(posedge hclk) disable iff (!hresetn)
      hrdata[31:16] == 16'h0000;
   endproperty
   a_read_high: assert property (p_read_high) else $error("upper read bits set");

   c_write_lo: cover property (@(posedge hclk) disable iff (!hresetn) wr_lo);
   c_write_lr: cover property (@(posedge hclk) disable iff (!hresetn) wr_lr && hwdata[0]);
   c_read:     cover property (@(posedge hclk) disable iff (!hresetn) rd_pend);
   c_code_max: cover property (@(posedge hclk) disable iff (!hresetn) codes[0] == 3'h7);
   c_read_void: cover property (@(posedge hclk) disable iff (!hresetn)
                                rd_pend && idx_pend > mix_gain_pkg::IDX_LEFT_REC);

endmodule : mixer_gain_config_regs

// *** include/mix_gain_pkg.sv ***
// Package for the mixer gain register bank: offsets, field layout, reset values, gain steps.
// Assumes a 32-bit AHB-Lite bus with word-aligned registers.
package mix_gain_pkg;

   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_LEFT_OUT  = 8'h60;
   localparam logic [7:0] IDX_RIGHT_OUT = 8'h61;
   localparam logic [7:0] IDX_LEFT_REC  = 8'h62;
   localparam int         ADDR_SHIFT    = 2;

   // Field positions (low bit of each 3-bit code).
   localparam int POS_AUX_L_OUT_L  = 9;
   localparam int POS_AMP_R_OUT_L  = 5;
   localparam int POS_AMP_L_OUT_L  = 1;
   localparam int POS_AUX_R_OUT_R  = 13;
   localparam int POS_AMP_R_OUT_R  = 5;
   localparam int POS_AMP_L_OUT_R  = 1;
   localparam int POS_AUX_L_REC_L  = 9;
   localparam int POS_SEC_L_REC_L  = 1;
   localparam int POS_BOOST        = 0;

   // Reset values and writable masks.
   localparam logic [2:0]  GAIN_RESET   = 3'h0;
   localparam logic        BOOST_RESET  = 1'b0;
   localparam logic [15:0] MASK_LEFT_OUT  = 16'h0eee;
   localparam logic [15:0] MASK_RIGHT_OUT = 16'he0ee;
   localparam logic [15:0] MASK_LEFT_REC  = 16'h0e0f;

   // Gain in dB for each code; code 0 disconnects the path.
   localparam int GAIN_MIN_DB  = -12;
   localparam int GAIN_STEP_DB = 3;
   localparam int BOOST_DB     = 20;

   // AHB constants.
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
   localparam logic       HRESP_OKAY    = 1'b0;

   // One mixer path as seen by the analogue stage.
   typedef struct packed {
      logic             connect;
      logic signed [7:0] gain_db;
   } path_ctrl_t;

endpackage : mix_gain_pkg

// *** verilog/gain_decode.sv ***
// Decoder from a 3-bit mixer gain code to a connect flag and a gain in dB.
// Assumes the analogue stage takes the decoded path setting directly.
`timescale 1ns/1ps
module gain_decode
(
   input  wire logic [2:0]              code,
   output mix_gain_pkg::path_ctrl_t     path
);

   // Code zero opens the path; others step up by a fixed amount.
   assign path.connect = (code != 3'h0);
   assign path.gain_db = 8'(mix_gain_pkg::GAIN_MIN_DB
                         + mix_gain_pkg::GAIN_STEP_DB * (int'(code) - 1));

endmodule : gain_decode

// *** dv/mixer_stage_model.sv ***
// Behavioural model of the analogue mixer gain stages fed by the register bank.
// Assumes each path arrives as a decoded connect flag and a signed gain in dB.
`timescale 1ns/1ps
module mixer_stage_model
(
   input  mix_gain_pkg::path_ctrl_t paths [8],
   output logic                     range_fault
);
   // A connected stage only has settings from -12 dB to +6 dB in 3 dB steps.
   always_comb
   begin
      range_fault = 1'b0;
      for (int k = 0; k < 8; k++)
      begin
         if (paths[k].connect && (paths[k].gain_db < -8'sd12 || paths[k].gain_db > 8'sd6
             || ((paths[k].gain_db + 8'sd12) % 3) != 0))
            range_fault = 1'b1;
      end
   end
endmodule : mixer_stage_model

// *** dv/mixer_gain_config_regs_tb.sv ***
// Self-checking bench for the mixer gain register bank over AHB-Lite.
// Assumes one master, zero-wait-state slave and the analogue stage model.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end end
module mixer_gain_config_regs_tb;
   logic                     hclk, hresetn, hsel, hwrite, hreadyout, hresp, boost, range_fault;
   logic [1:0]               htrans;
   logic [2:0]               hsize, c;
   logic [31:0]              haddr, hwdata, hrdata;
   logic [15:0]              word [3];
   logic [15:0]              mdl [3];
   logic [15:0]              msk [3];
   mix_gain_pkg::path_ctrl_t p [8];
   int                       fails, comparisons, cycles, i;

   mixer_gain_config_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .aux_l_to_out_l_gain(p[0]),
      .amp_r_to_out_l_gain(p[1]), .amp_l_to_out_l_gain(p[2]), .aux_r_to_out_r_gain(p[3]),
      .amp_r_to_out_r_gain(p[4]), .amp_l_to_out_r_gain(p[5]), .aux_l_to_rec_l_gain(p[6]),
      .second_l_to_rec_l_gain(p[7]), .amp_l_rec_boost(boost), .left_out_word(word[0]),
      .right_out_word(word[1]), .left_rec_word(word[2]));
   mixer_stage_model u_stage (.paths(p), .range_fault(range_fault));

   // Clock at 50 MHz and a cycle ceiling that cuts a hang short.
   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         $display("BAD timeout exp %h got %h", 0, cycles);
         summarize();
      end
   end

   // Expected gain for a nonzero code, one entry per documented setting.
   function automatic logic signed [7:0] exp_db(input logic [2:0] k);
      case (k)
         3'h1:    return -8'sd12;
         3'h2:    return -8'sd9;
         3'h3:    return -8'sd6;
         3'h4:    return -8'sd3;
         3'h5:    return 8'sd0;
         3'h6:    return 8'sd3;
         3'h7:    return 8'sd6;
         default: return 8'sd0;
      endcase
   endfunction : exp_db
   function automatic logic [31:0] addr_of(input int n);
      return 32'(mix_gain_pkg::IDX_LEFT_OUT + 8'(n)) << mix_gain_pkg::ADDR_SHIFT;
   endfunction : addr_of

   // One single word transfer: address phase, then data phase.
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= mix_gain_pkg::HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      `CHK("hresp", mix_gain_pkg::HRESP_OKAY, hresp)
   endtask : xfer
   task automatic wr(input int n, input logic [15:0] d);
      logic [31:0] r;
      xfer(1'b1, addr_of(n), {16'h0, d}, r);
      if (n < 3) mdl[n] = d & msk[n];
      #1;
   endtask : wr
   task automatic rd(input int n, input logic [15:0] e);
      logic [31:0] r;
      xfer(1'b0, addr_of(n), 32'h0, r);
      `CHK("hrdata", {16'h0, e}, r)
   endtask : rd
   task automatic chk_path(input string n, input logic [2:0] k, input mix_gain_pkg::path_ctrl_t g);
      `CHK(n, k != 3'h0, g.connect)
      if (k != 3'h0) `CHK(n, exp_db(k), g.gain_db)
   endtask : chk_path
   task automatic chk_out;
      for (int n = 0; n < 3; n++) `CHK("word", mdl[n], word[n])
      chk_path("aux_l_to_out_l", mdl[0][11:9], p[0]);
      chk_path("amp_r_to_out_l", mdl[0][7:5], p[1]);
      chk_path("amp_l_to_out_l", mdl[0][3:1], p[2]);
      chk_path("aux_r_to_out_r", mdl[1][15:13], p[3]);
      chk_path("amp_r_to_out_r", mdl[1][7:5], p[4]);
      chk_path("amp_l_to_out_r", mdl[1][3:1], p[5]);
      chk_path("aux_l_to_rec_l", mdl[2][11:9], p[6]);
      chk_path("second_l_to_rec_l", mdl[2][3:1], p[7]);
      `CHK("amp_l_rec_boost", mdl[2][0], boost)
      `CHK("range_fault", 1'b0, range_fault)
   endtask : chk_out
   task automatic do_reset;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      for (int n = 0; n < 3; n++) mdl[n] = 16'h0;
      #1;
      chk_out();
      for (int n = 0; n < 3; n++) rd(n, 16'h0);
   endtask : do_reset
   task automatic summarize;
      $display("counts: %0d comparisons, %0d fails", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize

   // Main sequence: reset, every code, random traffic, unmapped place, reset again.
   initial
   begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; fails = 0; comparisons = 0; cycles = 0;
      msk[0] = mix_gain_pkg::MASK_LEFT_OUT; msk[1] = mix_gain_pkg::MASK_RIGHT_OUT;
      msk[2] = mix_gain_pkg::MASK_LEFT_REC;
      void'($urandom(32'hf79d693c));
      do_reset();
      $display("test reset done");
      for (int k = 0; k < 8; k++)
      begin
         c = 3'(k);
         for (int n = 0; n < 3; n++) wr(n, {c, 1'b0, c, 1'b0, c, 1'b0, c, c[0]});
         chk_out();
      end
      $display("test codes done");
      repeat (30)
      begin
         i = $urandom_range(2);
         wr(i, 16'($urandom));
         rd(i, mdl[i]);
         chk_out();
      end
      $display("test random done");
      wr(3, 16'hffff);
      rd(3, 16'h0);
      chk_out();
      $display("test unmapped done");
      do_reset();
      $display("test second reset done");
      summarize();
   end
endmodule : mixer_gain_config_regs_tb
